// >>> rtl/fnb_pkg.sv
`default_nettype none
package fnb_pkg;
    // Bus widths of the flash pins
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;

    // Clock rate and internal ready time after reset
    localparam int CLK_MHZ       = 250;
    localparam int READY_TIME_NS = 100;
    localparam int READY_CYC     = (READY_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int RDY_CNT_W     = 8;

    // Avalon register map, byte addresses
    localparam int          AV_ADDR_W = 4;
    localparam logic [3:0]  REG_CFG   = 4'h0;
    localparam logic [3:0]  REG_STAT  = 4'h4;

    // Configuration register fields and reset value
    localparam int          CFG_ASYNC   = 0;
    localparam int          CFG_K_FALL  = 1;
    localparam int          CFG_WAIT    = 2;
    localparam int          CFG_WPOL    = 3;
    localparam int          CFG_WADV    = 4;
    localparam int          CFG_W       = 5;
    localparam logic [4:0]  CFG_RESET   = 5'h00;

    // Status register fields
    localparam int STAT_STATE = 0;
    localparam int STAT_LKDN  = 3;
    localparam int STAT_RWIN  = 4;

    // Control states, Gray along reset, hold, release, first capture, run
    typedef enum logic [2:0] {
        ST_RST   = 3'b000,
        ST_HOLD  = 3'b001,
        ST_REL   = 3'b011,
        ST_CAPT  = 3'b010,
        ST_RUN   = 3'b110
    } fnb_state_e;

    // Control pins from the far party, sampled on ref_clk_in
    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              le_n;
        logic              kclk;
        logic              hw_reset_n;
        logic              wp_n;
        logic [ADDR_W-1:0] word_addr_bus;
    } fnb_pin_s;
endpackage
`default_nettype wire

// >>> rtl/fnb_pin_ctrl.sv
`default_nettype none
module fnb_pin_ctrl (
    // Clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         srst_in,
    // Flash control and address pins
    input  wire fnb_pkg::fnb_pin_s            pins_in,
    // Data pins, three-signal form
    input  wire logic [fnb_pkg::DATA_W-1:0]   word_data_bus_in,
    output logic      [fnb_pkg::DATA_W-1:0]   word_data_bus_out,
    output logic                              word_data_bus_oe_out,
    // Ready/wait pin, three-signal form
    input  wire logic                         rdy_wait_in,
    output logic                              rdy_wait_out,
    output logic                              rdy_wait_oe_out,
    // Array read port
    output logic                              arr_rd_out,
    output logic      [fnb_pkg::ADDR_W-1:0]   arr_addr_out,
    input  wire logic [fnb_pkg::DATA_W-1:0]   arr_data_in,
    input  wire logic                         arr_valid_in,
    // Command interface port
    output logic                              cmd_wr_out,
    output logic      [fnb_pkg::ADDR_W-1:0]   cmd_addr_out,
    output logic      [fnb_pkg::DATA_W-1:0]   cmd_data_out,
    // Protection change request
    input  wire logic                         lk_chg_req_in,
    input  wire logic                         lk_down_blk_in,
    output logic                              lk_chg_ok_out,
    // Power and protection status
    output logic                              lock_all_out,
    output logic                              active_out,
    output logic                              standby_out,
    output logic                              low_pwr_out,
    // Avalon-MM slave
    input  wire logic [fnb_pkg::AV_ADDR_W-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    output logic      [31:0]                  avs_readdata,
    output logic                              avs_waitrequest
);
    fnb_pkg::fnb_state_e             state;       // Control state
    logic [fnb_pkg::CFG_W-1:0]       cfg;         // Configuration register
    logic [fnb_pkg::RDY_CNT_W-1:0]   rdy_cnt;     // Internal ready counter
    logic [fnb_pkg::ADDR_W-1:0]      addr_lat;    // Address latch
    logic [fnb_pkg::ADDR_W-1:0]      burst_addr;  // Next burst word
    logic                            k_q;         // Burst clock last sample
    logic                            we_q;        // Write enable last sample
    logic                            ce_q;        // Chip enable last sample
    logic                            word_valid;  // Output word is good
    logic                            av_ack;      // Bus answer cycle
    logic                            dev_rst;     // Any reset source
    logic                            k_edge;      // Chosen burst clock edge
    logic                            sync_rd;     // Synchronous read active
    logic                            ready_mode;  // Handshake in ready role
    logic                            selected;    // Chip and output enabled
    logic                            wr_edge;     // First enable rising edge
    logic                            next_word_valid;
    logic                            wait_raw;    // Wait before polarity

    // Reset pin and bus reset both feed the device reset
    assign dev_rst    = srst_in | ~pins_in.hw_reset_n;
    assign ready_mode = ~cfg[fnb_pkg::CFG_WAIT];
    assign selected   = ~pins_in.ce_n & ~pins_in.oe_n;
    assign sync_rd    = ~cfg[fnb_pkg::CFG_ASYNC] & pins_in.we_n;

    // Clock edge only counts in synchronous reads
    assign k_edge = sync_rd & (cfg[fnb_pkg::CFG_K_FALL] ? (k_q & ~pins_in.kclk)
                                                          : (~k_q & pins_in.kclk));

    // Whichever enable rises first ends the write
    assign wr_edge = (~we_q & pins_in.we_n & ~pins_in.ce_n)
                   | (~ce_q & pins_in.ce_n & ~pins_in.we_n)
                   | (~we_q & ~ce_q & pins_in.we_n & pins_in.ce_n);

    // Pin history for edge detection
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            k_q  <= 1'b0;
            we_q <= 1'b1;
            ce_q <= 1'b1;
        end else begin
            k_q  <= pins_in.kclk;
            we_q <= pins_in.we_n;
            ce_q <= pins_in.ce_n;
        end
    end

    // Reset, handshake and first capture sequencing
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            state   <= fnb_pkg::ST_RST;
            rdy_cnt <= '0;
        end else begin
            unique case (state)
                fnb_pkg::ST_RST: begin
                    state   <= fnb_pkg::ST_HOLD;
                    rdy_cnt <= '0;
                end
                fnb_pkg::ST_HOLD: begin
                    // Line pulled low until internally ready
                    if (rdy_cnt == fnb_pkg::RDY_CNT_W'(fnb_pkg::READY_CYC - 1)) begin
                        state <= fnb_pkg::ST_REL;
                    end
                    rdy_cnt <= rdy_cnt + 1'b1;
                end
                fnb_pkg::ST_REL: begin
                    // Both parties must let go of the wired-AND
                    if (rdy_wait_in) begin
                        state <= fnb_pkg::ST_CAPT;
                    end
                end
                fnb_pkg::ST_CAPT: begin
                    // Start address taken on the first clock capture
                    if (k_edge & ~pins_in.le_n) begin
                        state <= fnb_pkg::ST_RUN;
                    end
                end
                fnb_pkg::ST_RUN: begin
                    // Host pull-down restarts the synchronous read
                    if (ready_mode & ~cfg[fnb_pkg::CFG_ASYNC] & ~rdy_wait_in) begin
                        state <= fnb_pkg::ST_REL;
                    end
                end
                default: state <= fnb_pkg::ST_RST;
            endcase
        end
    end

    // Address latch, transparent low in async mode and writes, clocked in sync reads, frozen high
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            addr_lat <= '0;
        end else if (~pins_in.le_n & (cfg[fnb_pkg::CFG_ASYNC] | ~pins_in.we_n)) begin
            addr_lat <= pins_in.word_addr_bus;
        end else if (k_edge & ~pins_in.le_n) begin
            addr_lat <= pins_in.word_addr_bus;
        end
    end

    // Burst address counter and array requests
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            burst_addr   <= '0;
            arr_rd_out   <= 1'b0;
            arr_addr_out <= '0;
        end else begin
            arr_rd_out <= 1'b0;
            if ((state == fnb_pkg::ST_CAPT || state == fnb_pkg::ST_RUN)
                && k_edge && ~pins_in.le_n) begin
                burst_addr <= pins_in.word_addr_bus;
            end else if (state == fnb_pkg::ST_RUN && k_edge && selected
                         && (rdy_wait_in | ~ready_mode)) begin
                arr_rd_out   <= 1'b1;
                arr_addr_out <= burst_addr;
                burst_addr   <= burst_addr + 1'b1;
            end else if (state == fnb_pkg::ST_RUN && cfg[fnb_pkg::CFG_ASYNC]
                         && selected && pins_in.we_n) begin
                // Asynchronous read, one lookup per cycle
                arr_rd_out   <= 1'b1;
                arr_addr_out <= pins_in.le_n ? addr_lat : pins_in.word_addr_bus;
            end
        end
    end

    // Word validity: set by array, dropped by new request or deselect
    always_comb begin
        next_word_valid = word_valid;
        if (pins_in.ce_n | arr_rd_out) begin
            next_word_valid = 1'b0;
        end
        if (arr_valid_in) begin
            next_word_valid = 1'b1;
        end
    end

    // Output word register
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            word_valid        <= 1'b0;
            word_data_bus_out <= '0;
        end else begin
            word_valid <= next_word_valid;
            if (arr_valid_in) begin
                word_data_bus_out <= arr_data_in;
            end
        end
    end

    // Data drivers: only when active, selected, reading and handshake free
    assign word_data_bus_oe_out = (state == fnb_pkg::ST_RUN) & selected & pins_in.we_n
                                & word_valid
                                & ~(ready_mode & ~cfg[fnb_pkg::CFG_ASYNC] & ~rdy_wait_in);

    // Early wait looks at next cycle's validity
    assign wait_raw = cfg[fnb_pkg::CFG_WADV] ? ~next_word_valid : ~word_valid;

    // Handshake pin: open-drain ready, or driven wait while running and selected
    always_comb begin
        rdy_wait_out    = 1'b0;
        rdy_wait_oe_out = 1'b0;
        if (state == fnb_pkg::ST_HOLD) begin
            rdy_wait_oe_out = 1'b1;
        end else if (~ready_mode && state == fnb_pkg::ST_RUN && selected) begin
            rdy_wait_oe_out = 1'b1;
            rdy_wait_out    = cfg[fnb_pkg::CFG_WPOL] ? wait_raw : ~wait_raw;
        end
    end

    // Command capture, only in the run state after the first address capture
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            cmd_wr_out   <= 1'b0;
            cmd_addr_out <= '0;
            cmd_data_out <= '0;
        end else begin
            cmd_wr_out <= 1'b0;
            if (wr_edge && state == fnb_pkg::ST_RUN) begin
                cmd_wr_out   <= 1'b1;
                cmd_addr_out <= pins_in.le_n ? addr_lat : pins_in.word_addr_bus;
                cmd_data_out <= word_data_bus_in;
            end
        end
    end

    // Protection change grant follows the guard pin
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            lk_chg_ok_out <= 1'b0;
        end else begin
            lk_chg_ok_out <= lk_chg_req_in & (~lk_down_blk_in | pins_in.wp_n);
        end
    end

    // Power and lock status; all blocks lock while in reset
    always_ff @(posedge ref_clk_in) begin
        lock_all_out <= dev_rst;
        active_out   <= ~pins_in.ce_n & pins_in.hw_reset_n;
        standby_out  <= pins_in.ce_n;
        low_pwr_out  <= ~pins_in.hw_reset_n;
    end

    // One wait state per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~av_ack;

    // Bus answer and read data
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            av_ack       <= 1'b0;
            avs_readdata <= '0;
        end else begin
            av_ack <= (avs_read | avs_write) & ~av_ack;
            if (avs_read & ~av_ack) begin
                unique case (avs_address)
                    fnb_pkg::REG_CFG:  avs_readdata <= 32'(cfg);
                    fnb_pkg::REG_STAT: avs_readdata <= 32'({rdy_wait_in, ~pins_in.wp_n,
                                                             state});
                    default:           avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration register; a device reset restores it over any write
    always_ff @(posedge ref_clk_in) begin
        if (dev_rst) begin
            cfg <= fnb_pkg::CFG_RESET;
        end else if (avs_write && av_ack && avs_address == fnb_pkg::REG_CFG) begin
            cfg <= avs_writedata[fnb_pkg::CFG_W-1:0];
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_left_reset;
        $fell(dev_rst) ##1 (state == fnb_pkg::ST_HOLD);
    endsequence

    a_hold_pulls_low: assert property (
        s_left_reset |-> (rdy_wait_oe_out && !rdy_wait_out) [*8])
        else $error("handshake not held low after reset");

    a_no_start_low: assert property (
        (state == fnb_pkg::ST_REL && !rdy_wait_in) |=> (state != fnb_pkg::ST_CAPT))
        else $error("start taken while handshake low");

    a_deselect_float: assert property (
        pins_in.ce_n |-> !word_data_bus_oe_out)
        else $error("data driven while deselected");

    a_reset_float: assert property (
        !pins_in.hw_reset_n |=> (!word_data_bus_oe_out && !rdy_wait_oe_out))
        else $error("outputs driven in reset");

    a_wait_float: assert property (
        (!ready_mode && (pins_in.ce_n || pins_in.oe_n)) |-> !rdy_wait_oe_out)
        else $error("wait driven while not selected");

    a_lock_guard: assert property (
        (lk_chg_req_in && lk_down_blk_in && !pins_in.wp_n && !dev_rst)
        |=> !lk_chg_ok_out)
        else $error("locked-down change granted under guard");

    sequence s_we_first;
        !pins_in.we_n && !pins_in.ce_n ##1 pins_in.we_n && !pins_in.ce_n;
    endsequence

    a_write_capture: assert property (
        (s_we_first ##0 (state == fnb_pkg::ST_RUN && !dev_rst))
        |=> (cmd_wr_out && cmd_data_out == $past(word_data_bus_in)))
        else $error("write not captured on enable rise");

    a_ready_no_data: assert property (
        (ready_mode && !cfg[fnb_pkg::CFG_ASYNC] && !rdy_wait_in) |-> !word_data_bus_oe_out)
        else $error("burst data driven while handshake low");

    a_cfg_restored: assert property (
        dev_rst |=> (cfg == fnb_pkg::CFG_RESET && lock_all_out))
        else $error("reset did not restore config and locks");

    a_k_ignored: assert property (
        (cfg[fnb_pkg::CFG_ASYNC] && pins_in.le_n && pins_in.we_n && !dev_rst
         && $stable(cfg)) |=> $stable(addr_lat))
        else $error("address moved on clock in async mode");
endmodule // fnb_pin_ctrl
`default_nettype wire

// >>> verification/fnb_host_model.sv
`default_nettype none
// Host end of the wired-AND handshake line, external pull-up included
module fnb_host_model (
    // Device side of the pin
    input  wire logic dev_lvl_in,
    input  wire logic dev_oe_in,
    // Host start line, high while the host is not ready
    input  wire logic host_low_in,
    // Resolved line level
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pull-up wins only when neither party drives low
    assign line_out = (dev_oe_in ? dev_lvl_in : 1'b1) & ~host_low_in;
endmodule // fnb_host_model
`default_nettype wire

// >>> verification/fnb_tb.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // Design signals, named as the ports
    logic              ref_clk_in, srst_in, rdy_wait_in, arr_valid_in, lk_chg_req_in;
    fnb_pkg::fnb_pin_s pins_in;
    logic [15:0]       word_data_bus_in, word_data_bus_out, arr_data_in, cmd_data_out, wd;
    logic [22:0]       arr_addr_out, cmd_addr_out, a0, a1;
    logic              word_data_bus_oe_out, rdy_wait_out, rdy_wait_oe_out, arr_rd_out;
    logic              cmd_wr_out, lk_down_blk_in, lk_chg_ok_out, lock_all_out, v1;
    logic              active_out, standby_out, low_pwr_out, avs_waitrequest;
    logic              avs_read, avs_write, host_low;
    logic [3:0]        avs_address;
    logic [31:0]       avs_writedata, avs_readdata, seed, rd;
    int                bad_count, check_count, rd_cnt, n0;

    fnb_pin_ctrl i_fnb_pin_ctrl (
        .ref_clk_in, .srst_in, .pins_in, .word_data_bus_in, .word_data_bus_out,
        .word_data_bus_oe_out, .rdy_wait_in, .rdy_wait_out, .rdy_wait_oe_out,
        .arr_rd_out, .arr_addr_out, .arr_data_in, .arr_valid_in, .cmd_wr_out,
        .cmd_addr_out, .cmd_data_out, .lk_chg_req_in, .lk_down_blk_in, .lk_chg_ok_out,
        .lock_all_out, .active_out, .standby_out, .low_pwr_out, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    fnb_host_model i_fnb_host_model (.dev_lvl_in(rdy_wait_out), .dev_oe_in(rdy_wait_oe_out),
        .host_low_in(host_low), .line_out(rdy_wait_in));

    // Array stand-in answers one cycle after each request
    always @(posedge ref_clk_in) begin
        arr_valid_in <= arr_rd_out;
        arr_data_in  <= word_of(arr_addr_out);
        if (arr_rd_out === 1'b1) rd_cnt <= rd_cnt + 1;
    end
    // Free-running bench clock
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    // Xorshift source, fixed start for repeatable runs
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Word held at an array address
    function automatic logic [15:0] word_of(input logic [22:0] a);
        return a[15:0] ^ 16'h5a3c;
    endfunction
    // Single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo();
        bad_count++;
        $display("FAIL %0t timeout", $time);
        close_out();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // Bounded wait for a read or a command pulse
    task automatic wait_hi(input bit cmd);
        for (int n = 0; n < 10; n++) begin
            @(posedge ref_clk_in);
            if ((cmd ? cmd_wr_out : arr_rd_out) === 1'b1) return;
        end
        tmo();
    endtask
    // Avalon access; request held until waitrequest is seen low
    task automatic av(input bit wr, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        for (int n = 0; n < 10; n++) begin
            @(posedge ref_clk_in);
            if (avs_waitrequest === 1'b0) begin
                rd = avs_readdata;
                avs_read  <= 1'b0;
                avs_write <= 1'b0;
                cyc(1);
                return;
            end
        end
        tmo();
    endtask
    // One burst clock pulse with no check
    task automatic ktog();
        pins_in.kclk <= 1'b1;
        cyc(2);
        pins_in.kclk <= 1'b0;
        cyc(2);
    endtask
    // Burst clock rising edge, word checked on the data pins
    task automatic kread(input logic [22:0] exp_a);
        pins_in.kclk <= 1'b1;
        wait_hi(0);
        chk(arr_addr_out, exp_a, "burst addr");
        cyc(2);
        chk(word_data_bus_oe_out, 1, "data oe");
        chk(word_data_bus_out, word_of(exp_a), "burst word");
        pins_in.kclk <= 1'b0;
        cyc(2);
    endtask
    // Address capture then latch closed
    task automatic capture(input logic [22:0] a);
        pins_in.le_n          <= 1'b0;
        pins_in.word_addr_bus <= a;
        ktog();
        pins_in.le_n <= 1'b1;
        cyc(1);
    endtask

    // Main sequence
    initial begin
        seed = 32'h0000_000f;
        {bad_count, check_count} = '0;
        srst_in = 1'b1;
        host_low = 1'b1;
        // Deselected, output enable low before clocking, latch enable high
        pins_in = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 23'h0};
        {word_data_bus_in, lk_chg_req_in, lk_down_blk_in} = '0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        cyc(2);
        srst_in <= 1'b0;
        cyc(3);
        chk({rdy_wait_oe_out, rdy_wait_out}, 2'b10, "hold low");
        av(0, fnb_pkg::REG_CFG, 0);
        chk(rd, fnb_pkg::CFG_RESET, "cfg reset");
        cyc(fnb_pkg::READY_CYC + 4);
        chk(rdy_wait_oe_out, 0, "released");
        av(0, fnb_pkg::REG_STAT, 0);
        chk(rd[2:0], fnb_pkg::ST_REL, "waits for line");
        host_low <= 1'b0;
        cyc(3);
        av(0, fnb_pkg::REG_STAT, 0);
        chk(rd[2:0], fnb_pkg::ST_CAPT, "capture pending");
        // First capture and a short burst
        pins_in.ce_n <= 1'b0;
        a0 = 23'(xs());
        capture(a0);
        av(0, fnb_pkg::REG_STAT, 0);
        chk(rd[2:0], fnb_pkg::ST_RUN, "running");
        for (int i = 0; i < 4; i++) kread(a0 + 23'(i));
        // Deselect and reselect
        pins_in.ce_n <= 1'b1;
        cyc(3);
        chk({word_data_bus_oe_out, standby_out, active_out}, 3'b010, "deselect");
        pins_in.ce_n <= 1'b0;
        cyc(3);
        chk(active_out, 1, "active");
        // Writes, both enable orders, burst clock toggling meanwhile
        pins_in.le_n <= 1'b0;
        pins_in.oe_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a1 = 23'(xs());
            wd = 16'(xs());
            pins_in.word_addr_bus <= a1;
            word_data_bus_in      <= wd;
            pins_in.we_n          <= 1'b0;
            n0 = rd_cnt;
            ktog();
            chk(rd_cnt, n0, "clock ignored in write");
            if (i[0]) pins_in.ce_n <= 1'b1;
            else pins_in.we_n <= 1'b1;
            wait_hi(1);
            chk(cmd_addr_out, a1, "cmd addr");
            chk(cmd_data_out, wd, "cmd data");
            // Write enable back up first, so reselecting cannot look like a write
            pins_in.we_n <= 1'b1;
            cyc(1);
            pins_in.ce_n <= 1'b0;
            cyc(1);
        end
        pins_in.le_n <= 1'b1;
        // Lock-down guard against every target kind
        for (int i = 0; i < 4; i++) begin
            pins_in.wp_n   <= i[0];
            lk_down_blk_in <= i[1];
            cyc(2);
            lk_chg_req_in <= 1'b1;
            cyc(1);
            lk_chg_req_in <= 1'b0;
            cyc(1);
            chk(lk_chg_ok_out, !i[1] || i[0], "lock change");
            av(0, fnb_pkg::REG_STAT, 0);
            chk(rd[3], !i[0], "guard status");
        end
        // Wait mode drives the line; polarity flips it
        pins_in.oe_n <= 1'b0;
        av(1, fnb_pkg::REG_CFG, 32'h0000_000c);
        cyc(2);
        chk(rdy_wait_oe_out, 1, "wait drives");
        v1 = rdy_wait_out;
        av(1, fnb_pkg::REG_CFG, 32'h0000_0004);
        cyc(2);
        chk(rdy_wait_out, !v1, "wait polarity");
        // Active-high wait, one cycle early, around one burst word
        av(1, fnb_pkg::REG_CFG, 32'h0000_001c);
        pins_in.kclk <= 1'b1;
        wait_hi(0);
        chk(rdy_wait_out, 1, "wait before data");
        cyc(1);
        chk(rdy_wait_out, 0, "early wait release");
        pins_in.kclk <= 1'b0;
        cyc(2);
        pins_in.oe_n <= 1'b1;
        cyc(3);
        chk(rdy_wait_oe_out, 0, "wait floats");
        // Host restarts the burst through the ready line
        av(1, fnb_pkg::REG_CFG, 0);
        pins_in.oe_n <= 1'b0;
        host_low <= 1'b1;
        cyc(3);
        n0 = rd_cnt;
        ktog();
        chk(rd_cnt, n0, "no read while held");
        chk(word_data_bus_oe_out, 0, "no data while held");
        host_low <= 1'b0;
        cyc(3);
        av(0, fnb_pkg::REG_STAT, 0);
        chk(rd[2:0], fnb_pkg::ST_CAPT, "restart");
        a0 = 23'(xs());
        capture(a0);
        kread(a0);
        // Falling burst clock edge chosen: rise ignored, fall reads next word
        av(1, fnb_pkg::REG_CFG, 32'h0000_0002);
        n0 = rd_cnt;
        pins_in.kclk <= 1'b1;
        cyc(3);
        chk(rd_cnt, n0, "no read on rise");
        pins_in.kclk <= 1'b0;
        wait_hi(0);
        chk(arr_addr_out, a0 + 23'd1, "falling edge read");
        cyc(2);
        // Asynchronous mode: flow-through, then frozen latch
        av(1, fnb_pkg::REG_CFG, 32'h0000_0001);
        pins_in.le_n          <= 1'b0;
        pins_in.word_addr_bus <= a1;
        cyc(4);
        chk(arr_addr_out, a1, "flow through");
        pins_in.le_n          <= 1'b1;
        pins_in.word_addr_bus <= ~a1;
        cyc(4);
        chk(arr_addr_out, a1, "latch frozen");
        // Unmapped place reads zero and takes no write
        av(1, 4'h8, 32'hffff_ffff);
        av(0, 4'h8, 0);
        chk(rd, 0, "unmapped");
        av(0, fnb_pkg::REG_CFG, 0);
        chk(rd, 1, "cfg kept");
        // Reset pin in mid-run
        pins_in.hw_reset_n <= 1'b0;
        cyc(3);
        chk({word_data_bus_oe_out, rdy_wait_oe_out, lock_all_out, low_pwr_out, active_out},
            5'b00110, "pin reset");
        av(0, fnb_pkg::REG_CFG, 0);
        chk(rd, fnb_pkg::CFG_RESET, "cfg cleared");
        pins_in.hw_reset_n <= 1'b1;
        cyc(3);
        chk({rdy_wait_oe_out, rdy_wait_out}, 2'b10, "hold again");
        av(0, fnb_pkg::REG_STAT, 0);
        chk(rd[2:0], fnb_pkg::ST_HOLD, "back to hold");
        close_out();
    end
endmodule // testbench
`default_nettype wire
